// ### hdl/usb_ctl_defines.svh
// Purpose: constants for the usb connect, reset and suspend control block
// Assumes: ref_clk at 40 MHz, one clock domain
// Notes: times are kept in ns, cycle counts derived from them
`ifndef USB_CTL_DEFINES_SVH
`define USB_CTL_DEFINES_SVH

`define CLK_PERIOD_NS 25
`define BUSRST_SE0_NS 2500
`define SUSP_IDLE_NS 3000000
`define SUSP_ENTER_MAX_NS 10000000
`define WAKE_HOLDOFF_NS 5000000
`define WAKE_DRIVE_NS 2000000
`define BUSRST_SE0_CYC ((`BUSRST_SE0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSP_IDLE_CYC (`SUSP_IDLE_NS / `CLK_PERIOD_NS)
`define SUSP_ENTER_MAX_CYC (`SUSP_ENTER_MAX_NS / `CLK_PERIOD_NS)
`define WAKE_HOLDOFF_CYC ((`WAKE_HOLDOFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_DRIVE_CYC (`WAKE_DRIVE_NS / `CLK_PERIOD_NS)

`define CFG_CONNECT_BIT 0
`define CFG_SHADOW_BIT 1
`define CFG_SCOPE_BIT 2
`define CFG_MASK_LSB 3
`define CFG_HOSTWAKE_BIT 6
`define CFG_RESET 7'h00
`define CFG_KEEP_MASK 7'h07

`define FLAG_BUSRST 0
`define FLAG_SUSP 1
`define FLAG_RESUME 2
`define FLAG_KEEP_ON_FNRST 3'h1

`define VEC_NONE 8'h00
`define VEC_BUS_RESET 8'h17
`define VEC_SUSPEND 8'h18
`define VEC_RESUME 8'h19
`define VEC_EXT_IRQ 8'h1A

`define LINE_SYNC_RESET 3'h1

`endif

// ### hdl/usb_ctl_pkg.sv
// Purpose: shared types of the usb connect, reset and suspend control block
// Assumes: nothing beyond the defines header
// Notes: one-hot state codes
package usb_ctl_pkg;
    typedef enum logic [1:0] {
        LNK_ACTIVE = 2'b01,
        LNK_SUSPENDED = 2'b10
    } link_state_type;

    typedef enum logic [2:0] {
        WK_IDLE = 3'b001,
        WK_WAIT = 3'b010,
        WK_DRIVE = 3'b100
    } wake_state_type;
endpackage : usb_ctl_pkg

// ### hdl/bus_line_if.sv
// Purpose: carries the filtered bus line state to the control logic
// Assumes: single clock domain
// Notes: levels only, no pulses
`timescale 1ns/1ps
interface bus_line_if;
    logic lineJ;
    logic lineSe0;
    logic extIrq;
    modport mon(output lineJ, output lineSe0, output extIrq);
    modport ctl(input lineJ, input lineSe0, input extIrq);
endinterface : bus_line_if

// ### hdl/line_state_mon.sv
// Purpose: synchronises d-plus, d-minus and the external interrupt pin
// Assumes: pins asynchronous to ref_clk
// Notes: a change counts once the second and third stages agree
`timescale 1ns/1ps
`include "usb_ctl_defines.svh"
module line_state_mon (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic usbDpIn,
    input wire logic usbDmIn,
    input wire logic externalIrqIn,
    bus_line_if.mon lines
);
    logic [2:0] pinIn;
    logic [2:0] syncA_ff;
    logic [2:0] syncB_ff;
    logic [2:0] syncC_ff;
    logic [2:0] stable_ff;
    localparam logic [2:0] SYNC_RESET = `LINE_SYNC_RESET;

    assign pinIn = {externalIrqIn, usbDmIn, usbDpIn};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                syncA_ff[i] <= SYNC_RESET[i];
                syncB_ff[i] <= SYNC_RESET[i];
                syncC_ff[i] <= SYNC_RESET[i];
                stable_ff[i] <= SYNC_RESET[i];
            end else begin
                syncA_ff[i] <= pinIn[i];
                syncB_ff[i] <= syncA_ff[i];
                syncC_ff[i] <= syncB_ff[i];
                // one-cycle glitch on stage two never reaches the output
                if (syncB_ff[i] == syncC_ff[i]) begin
                    stable_ff[i] <= syncC_ff[i];
                end
            end
        end
    end

    assign lines.lineJ = stable_ff[0] && !stable_ff[1];
    assign lines.lineSe0 = !stable_ff[0] && !stable_ff[1];
    assign lines.extIrq = stable_ff[2];
endmodule : line_state_mon

// ### hdl/resume_driver.sv
// Purpose: upstream remote wake-up signalling timer
// Assumes: suspended is a level from the control logic
// Notes: a request made too early is held until the hold-off has passed
`timescale 1ns/1ps
`include "usb_ctl_defines.svh"
module resume_driver
    import usb_ctl_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYC = `WAKE_HOLDOFF_CYC,
    parameter int unsigned DRIVE_CYC = `WAKE_DRIVE_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic suspended,
    input wire logic hostWakeEn,
    input wire logic wakeReq,
    output logic driveK,
    output logic wakeDone
);
    wake_state_type state_ff;
    logic [19:0] heldCnt_ff;
    logic [19:0] driveCnt_ff;
    logic heldLong;

    assign heldLong = heldCnt_ff >= 20'(HOLDOFF_CYC);

    always_ff @(posedge ref_clk) begin
        if (!reset_n || !suspended) begin
            heldCnt_ff <= 20'h00000;
        end else if (!heldLong) begin
            heldCnt_ff <= heldCnt_ff + 20'h00001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff <= WK_IDLE;
            driveCnt_ff <= 20'h00000;
            driveK <= 1'b0;
            wakeDone <= 1'b0;
        end else begin
            wakeDone <= 1'b0;
            case (state_ff)
                WK_IDLE: begin
                    if (wakeReq && hostWakeEn) begin
                        state_ff <= WK_WAIT;
                    end
                end
                WK_WAIT: begin
                    if (!suspended) begin
                        state_ff <= WK_IDLE;
                    end else if (heldLong) begin
                        state_ff <= WK_DRIVE;
                        driveK <= 1'b1;
                        driveCnt_ff <= 20'h00000;
                    end
                end
                WK_DRIVE: begin
                    driveCnt_ff <= driveCnt_ff + 20'h00001;
                    if (driveCnt_ff == 20'(DRIVE_CYC - 1)) begin
                        state_ff <= WK_IDLE;
                        driveK <= 1'b0;
                        wakeDone <= 1'b1;
                    end
                end
                default: begin
                    state_ff <= WK_IDLE;
                    driveK <= 1'b0;
                end
            endcase
        end
    end
endmodule : resume_driver

// ### hdl/usb_connect_reset_suspend_ctrl.sv
// Purpose: pull-up connect, bus reset, suspend, resume and remote wake control
// Assumes: ref_clk keeps running while device clocks are gated
// Notes: firmware bits arrive through cfgWrite; flags clear through flagClear
`timescale 1ns/1ps
`include "usb_ctl_defines.svh"
module usb_connect_reset_suspend_ctrl
    import usb_ctl_pkg::*;
#(
    parameter int unsigned SE0_CYC = `BUSRST_SE0_CYC,
    parameter int unsigned SUSP_CYC = `SUSP_IDLE_CYC,
    parameter int unsigned LOWPWR_CYC = `SUSP_ENTER_MAX_CYC,
    parameter int unsigned HOLDOFF_CYC = `WAKE_HOLDOFF_CYC,
    parameter int unsigned DRIVE_CYC = `WAKE_DRIVE_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cfgWrite,
    input wire logic [6:0] cfgData,
    input wire logic idleSet,
    input wire logic [2:0] flagClear,
    input wire logic busPowered,
    input wire logic remoteWakeRequest,
    input wire logic usbDpIn,
    input wire logic usbDmIn,
    input wire logic externalIrqIn,
    output logic dplusPullupCtrlOut,
    output logic dplusPullupOe,
    output logic usbDpOut,
    output logic usbDmOut,
    output logic usbDOe,
    output logic resetOutPin,
    output logic chipResetOut,
    output logic bootShadowSel,
    output logic idleBit,
    output logic clocksOn,
    output logic suspendActive,
    output logic busResetFlag,
    output logic suspendRequestFlag,
    output logic resumeRequestFlag,
    output logic mcuIrqLine,
    output logic [7:0] irqVectorReg
);
    bus_line_if lines ();

    link_state_type state_ff;
    logic [6:0] cfg_ff;
    logic [2:0] flags_ff;
    logic [2:0] pend;
    logic [7:0] se0Cnt_ff;
    logic [19:0] idleCnt_ff;
    logic [19:0] suspCnt_ff;
    logic idle_ff;
    logic nxt_idleBit;
    logic clocksOn_ff;
    logic rstHold_ff;
    logic resetOutPin_ff;
    logic chipReset_ff;
    logic mcuIrqLine_ff;
    logic [7:0] irqVector_ff;
    logic busResetEvt;
    logic fnReset;
    logic suspendEvt;
    logic resumeEvt;
    logic forceIdle;
    logic driveK;
    logic wakeDone;

    line_state_mon u_mon (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .usbDpIn(usbDpIn),
        .usbDmIn(usbDmIn),
        .externalIrqIn(externalIrqIn),
        .lines(lines.mon)
    );

    resume_driver #(
        .HOLDOFF_CYC(HOLDOFF_CYC),
        .DRIVE_CYC(DRIVE_CYC)
    ) u_wake (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .suspended(state_ff == LNK_SUSPENDED),
        .hostWakeEn(cfg_ff[`CFG_HOSTWAKE_BIT]),
        .wakeReq(remoteWakeRequest),
        .driveK(driveK),
        .wakeDone(wakeDone)
    );

    // highest priority pending source wins the vector
    function automatic logic [7:0] vecOf(input logic [2:0] p, input logic ext);
        logic [7:0] v;
        v = `VEC_NONE;
        if (p[`FLAG_BUSRST]) begin
            v = `VEC_BUS_RESET;
        end else if (p[`FLAG_SUSP]) begin
            v = `VEC_SUSPEND;
        end else if (p[`FLAG_RESUME]) begin
            v = `VEC_RESUME;
        end else if (ext) begin
            v = `VEC_EXT_IRQ;
        end
        return v;
    endfunction : vecOf

    // bus reset: se0 held for the minimum reset time, one event per reset
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !lines.lineSe0) begin
            se0Cnt_ff <= 8'h00;
        end else if (se0Cnt_ff != 8'(SE0_CYC)) begin
            se0Cnt_ff <= se0Cnt_ff + 8'h01;
        end
    end

    assign busResetEvt = lines.lineSe0 && (se0Cnt_ff == 8'(SE0_CYC - 1));
    assign fnReset = busResetEvt && cfg_ff[`CFG_SCOPE_BIT];

    // firmware bits; connect, shadow and scope survive a function reset
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cfg_ff <= `CFG_RESET;
        end else if (cfgWrite) begin
            cfg_ff <= cfgData;
        end else if (fnReset) begin
            cfg_ff <= cfg_ff & `CFG_KEEP_MASK;
        end
    end

    // idle counter runs only while awake; it stops once suspend is seen
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !lines.lineJ || state_ff != LNK_ACTIVE) begin
            idleCnt_ff <= 20'h00000;
        end else if (idleCnt_ff != 20'(SUSP_CYC)) begin
            idleCnt_ff <= idleCnt_ff + 20'h00001;
        end
    end

    assign suspendEvt = state_ff == LNK_ACTIVE && lines.lineJ &&
        idleCnt_ff == 20'(SUSP_CYC - 1) + 20'h00001;

    // own k drive must not look like host resume
    assign resumeEvt = state_ff == LNK_SUSPENDED && !lines.lineJ && !driveK && !wakeDone;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff <= LNK_ACTIVE;
        end else begin
            case (state_ff)
                LNK_ACTIVE: begin
                    if (suspendEvt) begin
                        state_ff <= LNK_SUSPENDED;
                    end
                end
                LNK_SUSPENDED: begin
                    if (resumeEvt || wakeDone || fnReset) begin
                        state_ff <= LNK_ACTIVE;
                    end
                end
                default: begin
                    state_ff <= LNK_ACTIVE;
                end
            endcase
        end
    end

    // time spent suspended, for the low-power deadline
    always_ff @(posedge ref_clk) begin
        if (!reset_n || state_ff != LNK_SUSPENDED) begin
            suspCnt_ff <= 20'h00000;
        end else if (suspCnt_ff != 20'(LOWPWR_CYC)) begin
            suspCnt_ff <= suspCnt_ff + 20'h00001;
        end
    end

    // firmware that misses the deadline is parked; a self-powered part is left alone
    assign forceIdle = busPowered && state_ff == LNK_SUSPENDED &&
        suspCnt_ff == 20'(LOWPWR_CYC - 1);

    // resume and function reset win over a set in the same cycle; the external interrupt wins only when already idle
    always_comb begin
        nxt_idleBit = idle_ff;
        if (fnReset) begin
            nxt_idleBit = 1'b0;
        end else if (resumeEvt || (idle_ff && lines.extIrq)) begin
            nxt_idleBit = 1'b0;
        end else if (idleSet || forceIdle) begin
            nxt_idleBit = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            idle_ff <= 1'b0;
            clocksOn_ff <= 1'b1;
        end else begin
            idle_ff <= nxt_idleBit;
            clocksOn_ff <= !nxt_idleBit;
        end
    end

    // sticky flags: set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            flags_ff <= 3'h0;
        end else begin
            flags_ff <= (flags_ff & ~flagClear & (fnReset ? `FLAG_KEEP_ON_FNRST : 3'h7)) |
                {resumeEvt, suspendEvt, busResetEvt};
        end
    end

    assign pend = flags_ff & cfg_ff[`CFG_MASK_LSB +: 3];

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mcuIrqLine_ff <= 1'b0;
            irqVector_ff <= `VEC_NONE;
        end else begin
            mcuIrqLine_ff <= (|pend) || lines.extIrq;
            irqVector_ff <= vecOf(pend, lines.extIrq);
        end
    end

    // reset pin: high through master reset and through a qualifying bus reset
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rstHold_ff <= 1'b0;
            resetOutPin_ff <= 1'b1;
            chipReset_ff <= 1'b0;
        end else begin
            rstHold_ff <= fnReset || (rstHold_ff && lines.lineSe0);
            resetOutPin_ff <= fnReset || (rstHold_ff && lines.lineSe0);
            chipReset_ff <= fnReset || (rstHold_ff && lines.lineSe0);
        end
    end

    // value only matters while enabled; the board resistor does the pulling
    assign dplusPullupCtrlOut = cfg_ff[`CFG_CONNECT_BIT];
    assign dplusPullupOe = cfg_ff[`CFG_CONNECT_BIT];
    assign usbDpOut = 1'b0;
    assign usbDmOut = driveK;
    assign usbDOe = driveK;
    assign resetOutPin = resetOutPin_ff;
    assign chipResetOut = chipReset_ff;
    assign bootShadowSel = cfg_ff[`CFG_SHADOW_BIT];
    assign idleBit = idle_ff;
    assign clocksOn = clocksOn_ff;
    assign suspendActive = state_ff[1];
    assign busResetFlag = flags_ff[`FLAG_BUSRST];
    assign suspendRequestFlag = flags_ff[`FLAG_SUSP];
    assign resumeRequestFlag = flags_ff[`FLAG_RESUME];
    assign mcuIrqLine = mcuIrqLine_ff;
    assign irqVectorReg = irqVector_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    pullup_on_a: assert property (
        cfgWrite && cfgData[`CFG_CONNECT_BIT] |=> dplusPullupOe && dplusPullupCtrlOut)
        else $error("pull-up not enabled after connect");

    pullup_off_a: assert property (
        cfgWrite && !cfgData[`CFG_CONNECT_BIT] ##1 !(cfgWrite && cfgData[`CFG_CONNECT_BIT])
        |-> !dplusPullupOe ##1 !dplusPullupOe)
        else $error("pull-up driven while disconnected");

    keep_connect_a: assert property (
        busResetEvt && !cfgWrite |=> $stable(dplusPullupOe) && $stable(bootShadowSel))
        else $error("bus reset changed connect or shadow");

    shadow_map_a: assert property (
        cfgWrite && cfgData[`CFG_SHADOW_BIT] |=> bootShadowSel)
        else $error("shadow bit not applied");

    chip_reset_a: assert property (
        fnReset |=> chipResetOut && !idleBit && !suspendActive)
        else $error("function reset did not reach the chip");

    reset_pin_a: assert property (
        fnReset ##1 lines.lineSe0 |=> resetOutPin [*1] ##0 chipResetOut)
        else $error("reset pin not held during bus reset");

    pin_quiet_a: assert property (
        !rstHold_ff && !fnReset |=> !resetOutPin)
        else $error("reset pin asserted without a cause");

    keep_scope_a: assert property (
        busResetEvt && !cfgWrite |=> cfg_ff[`CFG_SCOPE_BIT] == $past(cfg_ff[`CFG_SCOPE_BIT]))
        else $error("bus reset changed the scope bit");

    reset_flag_a: assert property (
        busResetEvt |=> busResetFlag)
        else $error("bus reset flag not set");

    reset_vector_a: assert property (
        busResetEvt && cfg_ff[`CFG_MASK_LSB] && !cfg_ff[`CFG_SCOPE_BIT] && !cfgWrite
        ##1 !flagClear[`FLAG_BUSRST] && !cfgWrite
        |=> mcuIrqLine && irqVectorReg == 8'h17)
        else $error("bus reset vector not presented");

    suspend_detect_a: assert property (
        suspendEvt |-> $past(lines.lineJ, 2) && idleCnt_ff != 20'h00000)
        else $error("suspend without an idle bus");

    suspend_flag_a: assert property (
        suspendEvt && !fnReset |=> suspendActive && suspendRequestFlag)
        else $error("suspend flag missing");

    idle_gate_a: assert property (
        idleSet && !resumeEvt && !lines.extIrq && !fnReset |=> idleBit && !clocksOn)
        else $error("idle did not gate clocks");

    resume_wake_a: assert property (
        resumeEvt && !fnReset |=> clocksOn && !idleBit && resumeRequestFlag && !suspendActive)
        else $error("resume did not wake the device");

    ext_wake_a: assert property (
        idleBit && lines.extIrq && !fnReset |=> !idleBit && clocksOn && mcuIrqLine)
        else $error("external interrupt did not wake");

    irq_or_a: assert property (
        (|pend) || lines.extIrq |=> mcuIrqLine)
        else $error("interrupt line missed a source");

    irq_mask_a: assert property (
        !(|pend) && !lines.extIrq |=> !mcuIrqLine && irqVectorReg == 8'h00)
        else $error("interrupt without flag and mask");

    flag_hold_a: assert property (
        suspendRequestFlag && !flagClear[`FLAG_SUSP] && !fnReset |=> suspendRequestFlag)
        else $error("suspend flag dropped by itself");

    wake_gate_a: assert property (
        $rose(driveK) |-> suspendActive && cfg_ff[`CFG_HOSTWAKE_BIT] && u_wake.heldLong)
        else $error("remote wake driven outside suspend");

    wake_length_a: assert property (
        $rose(driveK) |-> driveK [*8])
        else $error("remote wake drive cut short");

    low_power_a: assert property (
        forceIdle && !lines.extIrq && !resumeEvt |=> idleBit)
        else $error("bus-powered part not parked in time");

    bus_reset_c: cover property (fnReset ##[1:20] !resetOutPin);
    suspend_resume_c: cover property (suspendEvt ##[1:1000] resumeEvt);
    remote_wake_c: cover property ($rose(driveK) ##[1:1000] wakeDone);
    ext_wake_c: cover property (idleBit ##1 lines.extIrq ##1 clocksOn);
endmodule : usb_connect_reset_suspend_ctrl

// ### verification/usb_host_model.sv
// Purpose: upstream host end of the bus lines
// Assumes: mode 0 released, 1 se0, 2 k, 3 j
// Notes: a released line falls to its pull level, never holds the last value
`timescale 1ns/1ps
module usb_host_model (
    input wire logic [1:0] mode,
    input wire logic pullupOn,
    input wire logic usbDOe,
    input wire logic usbDpOut,
    input wire logic usbDmOut,
    output logic usbDpIn,
    output logic usbDmIn
);
    always_comb begin
        if (usbDOe) begin
            usbDpIn = usbDpOut;
            usbDmIn = usbDmOut;
        end else if (mode != 2'h0) begin
            usbDpIn = (mode == 2'h3);
            usbDmIn = (mode == 2'h2);
        end else begin
            usbDpIn = pullupOn; // board pull-up only while enabled
            usbDmIn = 1'b0;
        end
    end
endmodule : usb_host_model

// ### verification/usb_connect_reset_suspend_ctrl_tb.sv
// Purpose: self-checking bench of the connect, reset and suspend control
// Assumes: shortened suspend, low-power, hold-off and drive counts
// Notes: bounded waits only; sync latency is allowed a few cycles of slack
`timescale 1ns/1ps
module usb_connect_reset_suspend_ctrl_tb;
    localparam int unsigned SUSP = 200;
    localparam int unsigned LOWPWR = 400;
    localparam int unsigned HOLDOFF = 300;
    localparam int unsigned DRIVE = 20;
    logic ref_clk = 1'b0, reset_n = 1'b0, cfgWrite = 1'b0, idleSet = 1'b0;
    logic busPowered = 1'b0, remoteWakeRequest = 1'b0, externalIrqIn = 1'b0;
    logic [6:0] cfgData = 7'h00;
    logic [2:0] flagClear = 3'h0;
    logic [1:0] mode = 2'h0;
    logic usbDpIn, usbDmIn, dplusPullupCtrlOut, dplusPullupOe, usbDpOut, usbDmOut, usbDOe;
    logic resetOutPin, chipResetOut, bootShadowSel, idleBit, clocksOn, suspendActive;
    logic busResetFlag, suspendRequestFlag, resumeRequestFlag, mcuIrqLine;
    logic [7:0] irqVectorReg;
    int n_errors = 0;
    int checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    usb_connect_reset_suspend_ctrl #(.SUSP_CYC(SUSP), .LOWPWR_CYC(LOWPWR), .HOLDOFF_CYC(HOLDOFF),
        .DRIVE_CYC(DRIVE)) dut (.ref_clk, .reset_n, .cfgWrite, .cfgData, .idleSet, .flagClear,
        .busPowered, .remoteWakeRequest, .usbDpIn, .usbDmIn, .externalIrqIn, .dplusPullupCtrlOut,
        .dplusPullupOe, .usbDpOut, .usbDmOut, .usbDOe, .resetOutPin, .chipResetOut, .bootShadowSel,
        .idleBit, .clocksOn, .suspendActive, .busResetFlag, .suspendRequestFlag, .resumeRequestFlag,
        .mcuIrqLine, .irqVectorReg);
    usb_host_model host (.mode, .pullupOn(dplusPullupOe & dplusPullupCtrlOut), .usbDOe, .usbDpOut,
        .usbDmOut, .usbDpIn, .usbDmIn);
    task automatic end_of_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic check(input string what, input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    function automatic logic sig(input int k);
        case (k)
            0: return suspendActive;
            1: return busResetFlag;
            2: return usbDOe;
            3: return resumeRequestFlag;
            default: return idleBit;
        endcase
    endfunction : sig
    task automatic waitFor(input int k, input logic v, input int maxc, output int n);
        n = 0;
        while (sig(k) !== v && n < maxc) begin
            cyc(1);
            n++;
        end
        if (sig(k) !== v) begin
            n_errors++;
            $display("[FAIL] wait %0d expected %b seen %b", k, v, sig(k));
            end_of_test();
        end
    endtask : waitFor
    task automatic cfg(input logic [6:0] d);
        cfgData = d;
        cfgWrite = 1'b1;
        cyc(1);
        cfgWrite = 1'b0;
        cyc(1);
    endtask : cfg
    task automatic clr(input logic [2:0] f);
        flagClear = f;
        cyc(1);
        flagClear = 3'h0;
        cyc(1);
    endtask : clr
    task automatic t_reset();
        check("rst pin", resetOutPin, 1'b1);
        check("pullup oe", dplusPullupOe, 1'b0);
        reset_n = 1'b1;
        cyc(2);
        check("rst pin off", resetOutPin, 1'b0);
        cfg(7'h01);
        check("pullup on", dplusPullupOe & dplusPullupCtrlOut, 1'b1);
        cfg(7'h00);
        check("pullup off", dplusPullupOe, 1'b0);
        cfg(7'h03);
        check("shadow", bootShadowSel, 1'b1);
    endtask : t_reset
    task automatic t_busreset(input logic scope, input logic doCfg);
        int n;
        if (doCfg) cfg({4'h1, scope, 2'h3});
        mode = 2'h1;
        waitFor(1, 1'b1, 120, n);
        cyc(2);
        check("rst pin", resetOutPin, scope);
        check("chip rst", chipResetOut, scope);
        check("connect kept", dplusPullupOe, 1'b1);
        check("shadow kept", bootShadowSel, 1'b1);
        check("irq", mcuIrqLine, ~scope);
        check("vec 17", irqVectorReg === 8'h17, ~scope);
        mode = 2'h3;
        cyc(6);
        check("rst pin end", resetOutPin, 1'b0);
        clr(3'h1);
        check("flag clr", busResetFlag | mcuIrqLine, 1'b0);
    endtask : t_busreset
    task automatic t_suspend(input logic [6:0] c);
        int n;
        cfg(c);
        mode = 2'h2;
        cyc(8);
        mode = 2'h0;
        waitFor(0, 1'b1, SUSP + 20, n);
        check("susp not early", n > SUSP, 1'b1);
        check("susp flag", suspendRequestFlag, 1'b1);
    endtask : t_suspend
    task automatic idleNow();
        idleSet = 1'b1;
        flagClear = 3'h6;
        cyc(1);
        idleSet = 1'b0;
        flagClear = 3'h0;
        cyc(1);
        check("idle", idleBit, 1'b1);
        check("clk off", clocksOn, 1'b0);
    endtask : idleNow
    task automatic t_resume();
        int n;
        t_suspend(7'h31);
        cyc(2);
        check("vec 18", irqVectorReg === 8'h18 && mcuIrqLine, 1'b1);
        idleNow();
        mode = 2'h2;
        waitFor(3, 1'b1, 20, n);
        cyc(1);
        check("idle clr", idleBit, 1'b0);
        check("clk on", clocksOn & ~suspendActive, 1'b1);
        check("vec 19", irqVectorReg === 8'h19 && mcuIrqLine, 1'b1);
        mode = 2'h3;
        clr(3'h4);
    endtask : t_resume
    task automatic t_extirq();
        int n;
        t_suspend(7'h01);
        idleNow();
        externalIrqIn = 1'b1;
        waitFor(4, 1'b0, 20, n);
        cyc(1);
        check("clk on", clocksOn, 1'b1);
        check("vec 1A", irqVectorReg === 8'h1A && mcuIrqLine, 1'b1);
        externalIrqIn = 1'b0;
        cyc(8);
        check("irq off", mcuIrqLine, 1'b0);
    endtask : t_extirq
    task automatic t_lowpwr();
        int n;
        busPowered = 1'b1;
        t_suspend(7'h01);
        waitFor(4, 1'b1, LOWPWR + 10, n);
        check("forced idle", n + 20 > LOWPWR, 1'b1);
        busPowered = 1'b0;
    endtask : t_lowpwr
    task automatic t_wake(input logic hostEn);
        int n;
        t_suspend({hostEn, 6'h01});
        remoteWakeRequest = 1'b1;
        cyc(1);
        remoteWakeRequest = 1'b0;
        if (!hostEn) begin
            cyc(HOLDOFF + 40);
            check("no wake", usbDOe | ~suspendActive, 1'b0);
        end else begin
            waitFor(2, 1'b1, HOLDOFF + 10, n);
            check("hold-off", n + 2 >= HOLDOFF, 1'b1);
            check("k state", usbDmOut & ~usbDpOut, 1'b1);
            waitFor(2, 1'b0, DRIVE + 5, n);
            check("drive len", n == DRIVE, 1'b1);
            cyc(1);
            check("awake", suspendActive, 1'b0);
        end
    endtask : t_wake
    initial begin
        cyc(16);
        t_reset();
        t_busreset(1'b0, 1'b1);
        t_busreset(1'b1, 1'b1);
        t_busreset(1'b1, 1'b0);
        t_resume();
        t_extirq();
        t_lowpwr();
        t_wake(1'b0);
        t_wake(1'b1);
        end_of_test();
    end
endmodule : usb_connect_reset_suspend_ctrl_tb
